// >>> verilog/masi_pkg.sv
// Constants, register map and field layout of the address and status indicator block
package masi_pkg;
  localparam int          MASI_AW          = 8;
  localparam int          MASI_DW          = 32;
  localparam logic [7:0]  MASI_LA_FACTORY  = 8'h50;
  localparam logic [7:0]  MASI_LA_MIN      = 8'h01;
  localparam logic [7:0]  MASI_LA_MAX      = 8'hFE;
  localparam logic [7:0]  MASI_LA_DYNAMIC  = 8'hFF;
  localparam int          MASI_SEC_SHIFT   = 3;
  localparam int          MASI_ERRQ_DEPTH  = 16;
  localparam int          MASI_ERR_W       = 16;
  localparam logic [15:0] MASI_NO_ERROR    = 16'h0000;
  localparam int          MASI_CLK_HZ      = 20_000_000;
  localparam int          MASI_ACCESS_NS   = 1000;
  localparam int          MASI_ACCESS_CYC  = (MASI_ACCESS_NS * (MASI_CLK_HZ / 1_000_000)) / 1000;
  localparam int          MASI_COMM_TO_US  = 100;
  localparam int          MASI_COMM_TO_CYC = MASI_COMM_TO_US * (MASI_CLK_HZ / 1_000_000);

  localparam logic [7:0] MASI_OFF_ADDR   = 8'h00;
  localparam logic [7:0] MASI_OFF_DYNLA  = 8'h04;
  localparam logic [7:0] MASI_OFF_STATUS = 8'h08;
  localparam logic [7:0] MASI_OFF_ERRQ   = 8'h0C;
  localparam logic [7:0] MASI_OFF_ERRPSH = 8'h10;
  localparam logic [7:0] MASI_OFF_IRQST  = 8'h14;
  localparam logic [7:0] MASI_OFF_IRQMSK = 8'h18;

  localparam int MASI_ST_FAILED   = 0;
  localparam int MASI_ST_ACCESS   = 1;
  localparam int MASI_ST_ERRORS   = 2;
  localparam int MASI_ST_OVERLOAD = 3;
  localparam int MASI_ST_OUT_CONN = 4;
  localparam int MASI_ST_DYNMODE  = 5;
  localparam int MASI_ST_TESTDONE = 6;

  localparam int MASI_IRQ_W       = 4;
  localparam int MASI_EV_SELFTEST = 0;
  localparam int MASI_EV_ERROR    = 1;
  localparam int MASI_EV_OVLD     = 2;
  localparam int MASI_EV_ERR_OVF  = 3;

  typedef enum logic [1:0] {MASI_POST, MASI_RUN, MASI_FAIL} masi_post_e;
endpackage : masi_pkg

// >>> verilog/masi_errq_mem.sv
// Small error queue storage with registered read data
module masi_errq_mem
  import masi_pkg::*;
#(
  parameter int W     = MASI_ERR_W,
  parameter int DEPTH = MASI_ERRQ_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : masi_errq_mem

// >>> verilog/masi_pulse_stretch.sv
// Holds a level for a fixed number of cycles after the last trigger
module masi_pulse_stretch
  import masi_pkg::*;
#(
  parameter int CYC = MASI_ACCESS_CYC,
  parameter int CW  = $clog2(CYC + 1)
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic trig,
  output logic      hold
);
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (trig) begin
      next_cnt = CW'(CYC);
    end else if (cnt != '0) begin
      next_cnt = cnt - CW'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign hold = (cnt != '0);
endmodule : masi_pulse_stretch

// >>> verilog/masi_top.sv
// Logical address selection, faceplate indicators, error queue and APB registers
module masi_top
  import masi_pkg::*;
#(
  parameter int         COMM_TO_CYC = MASI_COMM_TO_CYC,
  parameter logic [7:0] LA_SWITCH   = MASI_LA_FACTORY
) (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [MASI_AW-1:0]    paddr,
  input  wire logic [MASI_DW-1:0]    pwdata,
  output logic      [MASI_DW-1:0]    prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [7:0]            la_switch,
  input  wire logic                  comm_ok,
  input  wire logic                  err_push,
  input  wire logic [MASI_ERR_W-1:0] err_code,
  input  wire logic                  ext_over_level,
  output logic [7:0]                 logical_addr,
  output logic [7:0]                 secondary_addr,
  output logic                       led_failed,
  output logic                       led_access,
  output logic                       led_errors,
  output logic                       led_overload,
  output logic                       out_connect,
  output logic                       irq
);
  localparam int QAW = $clog2(MASI_ERRQ_DEPTH);
  localparam int TW  = $clog2(COMM_TO_CYC + 1);

  function automatic logic la_static(input logic [7:0] v);
    return (v >= MASI_LA_MIN) && (v <= MASI_LA_MAX);
  endfunction : la_static

  // Address selection state
  logic       dyn_mode;
  logic       next_dyn_mode;
  logic [7:0] la;
  logic [7:0] next_la;
  logic [7:0] dyn_la;
  logic [7:0] next_dyn_la;
  logic       strap_done;
  logic       next_strap_done;

  // Self-test state
  masi_post_e    post;
  masi_post_e    next_post;
  logic [TW-1:0] tmr;
  logic [TW-1:0] next_tmr;

  // Error queue state
  logic [QAW-1:0] wp;
  logic [QAW-1:0] next_wp;
  logic [QAW-1:0] rp;
  logic [QAW-1:0] next_rp;
  logic [QAW:0]   cnt;
  logic [QAW:0]   next_cnt;
  logic           pop_pend;
  logic           next_pop_pend;

  // Indicators and bus
  logic                  ovl;
  logic                  next_ovl;
  logic                  acc_led;
  logic                  next_acc_led;
  logic [MASI_IRQ_W-1:0] irq_st;
  logic [MASI_IRQ_W-1:0] next_irq_st;
  logic [MASI_IRQ_W-1:0] irq_msk;
  logic [MASI_IRQ_W-1:0] next_irq_msk;
  logic [MASI_DW-1:0]    rdata;
  logic [MASI_DW-1:0]    next_rdata;
  logic                  rdy;
  logic                  next_rdy;
  logic                  serr;
  logic                  next_serr;
  logic                  irq_q;
  logic                  next_irq_q;

  logic                  wr;
  logic                  rd;
  logic                  acc_hold;
  logic                  q_push;
  logic                  q_pop;
  logic                  q_full;
  logic                  q_empty;
  logic [MASI_ERR_W-1:0] q_rdata;
  logic [MASI_ERR_W-1:0] push_code;
  logic [MASI_IRQ_W-1:0] ev;

  assign wr = psel && penable && pwrite && !rdy;
  // Queue read waits a cycle for data; that edge must not pop a second entry
  assign rd = psel && penable && !pwrite && !rdy && !pop_pend;

  masi_pulse_stretch #(.CYC(MASI_ACCESS_CYC)) u_acc (
    .clk   (clk),
    .arst_n(arst_n),
    .trig  (psel),
    .hold  (acc_hold)
  );

  masi_errq_mem #(.W(MASI_ERR_W), .DEPTH(MASI_ERRQ_DEPTH)) u_mem (
    .clk  (clk),
    .we   (q_push),
    .waddr(wp),
    .wdata(push_code),
    .raddr(rp),
    .rdata(q_rdata)
  );

  assign q_full  = (cnt == (QAW+1)'(MASI_ERRQ_DEPTH));
  assign q_empty = (cnt == '0);
  assign push_code = (wr && paddr == MASI_OFF_ERRPSH) ? pwdata[MASI_ERR_W-1:0] : err_code;
  assign q_push  = (err_push || (wr && paddr == MASI_OFF_ERRPSH) ||
                    (post == MASI_POST && next_post == MASI_FAIL)) && !q_full;
  // Read of the queue register pops on access, data returned one cycle later
  assign q_pop   = rd && paddr == MASI_OFF_ERRQ && !q_empty;

  always_comb begin
    ev = '0;
    ev[MASI_EV_SELFTEST] = (post == MASI_POST) && (next_post != MASI_POST);
    ev[MASI_EV_ERROR]    = q_push;
    ev[MASI_EV_OVLD]     = ext_over_level && !ovl;
    ev[MASI_EV_ERR_OVF]  = (err_push || (wr && paddr == MASI_OFF_ERRPSH)) && q_full;
  end

  always_comb begin
    next_strap_done = 1'b1;
    next_dyn_mode   = dyn_mode;
    next_la         = la;
    next_dyn_la     = dyn_la;
    // Switch captured once after reset release, never under the async reset
    if (!strap_done) begin
      next_dyn_mode = (la_switch == MASI_LA_DYNAMIC);
      if (la_static(la_switch)) begin
        next_la = la_switch;
      end
    end
    if (wr && paddr == MASI_OFF_DYNLA && dyn_mode) begin
      next_dyn_la = pwdata[7:0];
      next_la     = pwdata[7:0];
    end
  end

  always_comb begin
    next_post = post;
    next_tmr  = tmr;
    unique case (post)
      MASI_POST: begin
        if (comm_ok) begin
          next_post = MASI_RUN;
        end else if (tmr == TW'(COMM_TO_CYC)) begin
          next_post = MASI_FAIL;
        end else begin
          next_tmr = tmr + TW'(1);
        end
      end
      MASI_RUN:  next_post = MASI_RUN;
      MASI_FAIL: next_post = MASI_FAIL;
      default:   next_post = MASI_POST;
    endcase
  end

  always_comb begin
    next_wp       = wp;
    next_rp       = rp;
    next_cnt      = cnt;
    next_pop_pend = q_pop;
    if (q_push) begin
      next_wp = wp + QAW'(1);
    end
    if (q_pop) begin
      next_rp = rp + QAW'(1);
    end
    next_cnt = cnt + (QAW+1)'(q_push) - (QAW+1)'(q_pop);
  end

  always_comb begin
    next_ovl     = ext_over_level;
    next_acc_led = acc_hold || psel;
  end

  always_comb begin
    next_irq_msk = irq_msk;
    // Set wins over clear-on-read
    next_irq_st  = irq_st | ev;
    if (rd && paddr == MASI_OFF_IRQST) begin
      next_irq_st = ev;
    end
    if (wr && paddr == MASI_OFF_IRQMSK) begin
      next_irq_msk = pwdata[MASI_IRQ_W-1:0];
    end
    // Level output; no priority field exists locally
    next_irq_q = |(next_irq_st & next_irq_msk);
  end

  always_comb begin
    next_rdy   = psel && penable && !rdy && !(q_pop || pop_pend) ? 1'b1 : 1'b0;
    next_serr  = 1'b0;
    next_rdata = rdata;
    if (pop_pend) begin
      next_rdy   = 1'b1;
      next_rdata = {{(MASI_DW-MASI_ERR_W){1'b0}}, q_rdata};
    end
    if (rd) begin
      next_rdata = '0;
      unique case (paddr)
        MASI_OFF_ADDR: begin
          next_rdata[7:0]  = la;
          next_rdata[15:8] = la >> MASI_SEC_SHIFT;
          next_rdata[23:16] = la_switch;
        end
        MASI_OFF_DYNLA: next_rdata[7:0] = dyn_la;
        MASI_OFF_STATUS: begin
          next_rdata[MASI_ST_FAILED]   = led_failed;
          next_rdata[MASI_ST_ACCESS]   = led_access;
          next_rdata[MASI_ST_ERRORS]   = !q_empty;
          next_rdata[MASI_ST_OVERLOAD] = ovl;
          next_rdata[MASI_ST_OUT_CONN] = !ovl;
          next_rdata[MASI_ST_DYNMODE]  = dyn_mode;
          next_rdata[MASI_ST_TESTDONE] = (post != MASI_POST);
        end
        MASI_OFF_ERRQ: next_rdata[MASI_ERR_W-1:0] = MASI_NO_ERROR;
        MASI_OFF_ERRPSH: next_rdata = '0;
        MASI_OFF_IRQST: next_rdata[MASI_IRQ_W-1:0] = irq_st;
        MASI_OFF_IRQMSK: next_rdata[MASI_IRQ_W-1:0] = irq_msk;
        default: next_serr = 1'b1;
      endcase
    end
    if (wr) begin
      unique case (paddr)
        MASI_OFF_IRQMSK: next_serr = 1'b0;
        MASI_OFF_DYNLA, MASI_OFF_ERRPSH: next_serr = 1'b0;
        MASI_OFF_ADDR, MASI_OFF_STATUS, MASI_OFF_ERRQ, MASI_OFF_IRQST: next_serr = 1'b0;
        default: next_serr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_done <= 1'b0;
      dyn_mode   <= 1'b0;
      la         <= MASI_LA_FACTORY;
      dyn_la     <= MASI_LA_FACTORY;
    end else begin
      strap_done <= next_strap_done;
      dyn_mode   <= next_dyn_mode;
      la         <= next_la;
      dyn_la     <= next_dyn_la;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      post <= MASI_POST;
      tmr  <= '0;
    end else begin
      post <= next_post;
      tmr  <= next_tmr;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp       <= '0;
      rp       <= '0;
      cnt      <= '0;
      pop_pend <= 1'b0;
    end else begin
      wp       <= next_wp;
      rp       <= next_rp;
      cnt      <= next_cnt;
      pop_pend <= next_pop_pend;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ovl     <= 1'b0;
      acc_led <= 1'b0;
    end else begin
      ovl     <= next_ovl;
      acc_led <= next_acc_led;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_st  <= '0;
      irq_msk <= '0;
      irq_q   <= 1'b0;
    end else begin
      irq_st  <= next_irq_st;
      irq_msk <= next_irq_msk;
      irq_q   <= next_irq_q;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= '0;
      rdy   <= 1'b0;
      serr  <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rdy   <= next_rdy;
      serr  <= next_serr;
    end
  end

  // Output registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      logical_addr   <= MASI_LA_FACTORY;
      secondary_addr <= MASI_LA_FACTORY >> MASI_SEC_SHIFT;
      led_failed     <= 1'b1;
      led_errors     <= 1'b0;
      out_connect    <= 1'b0;
    end else begin
      logical_addr   <= next_la;
      secondary_addr <= next_la >> MASI_SEC_SHIFT;
      led_failed     <= (next_post != MASI_RUN);
      led_errors     <= (next_cnt != '0);
      // Held open until self-test passes as well
      out_connect    <= !next_ovl && (next_post == MASI_RUN);
    end
  end

  assign prdata       = rdata;
  assign pready       = rdy;
  assign pslverr      = serr;
  assign led_access   = acc_led;
  assign led_overload = ovl;
  assign irq          = irq_q;
endmodule : masi_top

// >>> bench/masi_top_chk.sv
// Assertions on the ports of the address and status block
module masi_top_chk
  import masi_pkg::*;
(
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       err_push,
  input wire logic       ext_over_level,
  input wire logic [7:0] logical_addr,
  input wire logic [7:0] secondary_addr,
  input wire logic       led_failed,
  input wire logic       led_access,
  input wire logic       led_errors,
  input wire logic       led_overload,
  input wire logic       out_connect
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  int idle;
  int next_idle;
  // Saturates so a long quiet spell cannot wrap
  always_comb begin
    next_idle = psel ? 0 : ((idle < 1000) ? idle + 1 : idle);
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idle <= 0;
    end else begin
      idle <= next_idle;
    end
  end
  chk_sec_addr: assert property ($stable(logical_addr)
    |-> secondary_addr == (logical_addr >> MASI_SEC_SHIFT)) else $error("secondary wrong");
  chk_fail_post: assert property (!$past(arst_n) |-> led_failed)
    else $error("failed lamp dark in self-test");
  chk_conn_pass: assert property (out_connect |-> !led_failed)
    else $error("output connected before pass");
  chk_acc_on: assert property (psel |=> led_access)
    else $error("access lamp dark");
  chk_acc_dark: assert property (idle > MASI_ACCESS_CYC + 2 |-> !led_access)
    else $error("access lamp lit while idle");
  chk_err_lamp: assert property (err_push |-> ##[1:2] led_errors)
    else $error("errors lamp dark");
  chk_ovl_lamp: assert property ($rose(ext_over_level) |=> led_overload)
    else $error("overload lamp dark");
  chk_out_disc: assert property (led_overload |-> !out_connect)
    else $error("output connected in overload");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_ready_cause: assert property (pready |-> psel && penable && !$past(pready))
    else $error("ready without access");
  chk_ready_bound: assert property (psel && penable |-> ##[0:3] pready)
    else $error("no ready");
  chk_slverr_pair: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule : masi_top_chk

bind masi_top masi_top_chk masi_top_chk_i (.clk(clk), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .err_push(err_push),
  .ext_over_level(ext_over_level), .logical_addr(logical_addr),
  .secondary_addr(secondary_addr), .led_failed(led_failed), .led_access(led_access),
  .led_errors(led_errors), .led_overload(led_overload), .out_connect(out_connect));

// >>> bench/masi_rm_model.sv
// Behavioural resource manager driving the APB side
module masi_rm_model
  import masi_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // Entered just after a rising edge; waits on pready, never a fixed count
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines must not keep showing the old value
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge clk);
  endtask : xfer
  // Unique multiple of eight, as a command module controller needs
  task automatic assign_la(input logic [7:0] la);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, MASI_OFF_DYNLA, {24'h00_0000, la & 8'hF8}, q, e);
  endtask : assign_la
endmodule : masi_rm_model

// >>> bench/tb.sv
// Self-checking bench for the address and status indicator block
module tb
  import masi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TO = 10;
  logic        clk = 1'b0, arst_n = 1'b0, comm_ok = 1'b0, err_push = 1'b0;
  logic        ext_over_level = 1'b0, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  la_switch = 8'h50, paddr, logical_addr, secondary_addr, sw;
  logic [31:0] pwdata, prdata, q, seed = 32'h0000_7121;
  logic [15:0] err_code = 16'h0000;
  logic        led_failed, led_access, led_errors, led_overload, out_connect, irq;
  logic [15:0] codes [$];
  int          err_count = 0, total_checks = 0, cyc = 0;
  always #25 clk = ~clk;
  masi_top #(.COMM_TO_CYC(TO)) masi_top_i (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .la_switch(la_switch), .comm_ok(comm_ok),
    .err_push(err_push), .err_code(err_code), .ext_over_level(ext_over_level),
    .logical_addr(logical_addr), .secondary_addr(secondary_addr), .led_failed(led_failed),
    .led_access(led_access), .led_errors(led_errors), .led_overload(led_overload),
    .out_connect(out_connect), .irq(irq));
  masi_rm_model masi_rm_model_i (.clk(clk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : check
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
    masi_rm_model_i.xfer(w, a, d, q, e);
  endtask : rw
  task automatic boot(input logic [7:0] s, input logic ok);
    arst_n <= 1'b0;
    la_switch <= s;
    comm_ok <= ok;
    repeat (20) @(posedge clk);
    check(logical_addr, MASI_LA_FACTORY, "reset address");
    arst_n <= 1'b1;
    repeat (TO + 6) @(posedge clk);
  endtask : boot
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      sw = (i == 0) ? 8'h01 : (i == 1) ? 8'hFE : (seed[7:0] % 8'd254) + 8'd1;
      boot(sw, 1'b1);
      check(logical_addr, sw, "static address");
      check(secondary_addr, sw >> 3, "secondary");
      check({out_connect, led_failed}, 2'b10, "self-test pass");
      rw(1'b1, MASI_OFF_DYNLA, 32'h0000_0060);
      check(logical_addr, sw, "dynamic write ignored");
    end
    $display("test static done");
    boot(MASI_LA_DYNAMIC, 1'b1);
    masi_rm_model_i.assign_la(8'h60);
    check({secondary_addr, logical_addr}, 16'h0C60, "assigned address");
    $display("test dynamic done");
    seed = lfsr(seed);
    err_code <= seed[15:0] | 16'h0001;
    boot(MASI_LA_FACTORY, 1'b0);
    comm_ok <= 1'b1;
    repeat (4) @(posedge clk);
    check({out_connect, led_failed, led_errors}, 3'b011, "self-test fail");
    rw(1'b0, MASI_OFF_ERRQ, 32'h0);
    check(q, {16'h0, seed[15:0] | 16'h0001}, "timeout code");
    rw(1'b0, MASI_OFF_ERRQ, 32'h0);
    check(q, 32'h0000_0000, "empty queue");
    check(led_errors, 1'b0, "errors lamp off");
    $display("test self-test fail done");
    boot(MASI_LA_FACTORY, 1'b1);
    rw(1'b0, MASI_OFF_IRQST, 32'h0);
    check(q[3:0], 4'h1, "self-test event");
    codes.delete();
    for (int i = 0; i <= MASI_ERRQ_DEPTH; i++) begin
      seed = lfsr(seed);
      err_push <= 1'b1;
      err_code <= seed[15:0];
      if (i < MASI_ERRQ_DEPTH) codes.push_back(seed[15:0]);
      @(posedge clk);
    end
    err_push <= 1'b0;
    repeat (3) @(posedge clk);
    check(irq, 1'b0, "masked irq");
    rw(1'b1, MASI_OFF_IRQMSK, 32'h0000_0008);
    repeat (2) @(posedge clk);
    check(irq, 1'b1, "overflow irq");
    rw(1'b0, MASI_OFF_IRQST, 32'h0);
    check(q[3:0], 4'hA, "event bits");
    repeat (2) @(posedge clk);
    check(irq, 1'b0, "irq cleared");
    foreach (codes[i]) begin
      check(led_errors, 1'b1, "errors lamp");
      rw(1'b0, MASI_OFF_ERRQ, 32'h0);
      check(q, {16'h0, codes[i]}, "queue order");
    end
    rw(1'b0, MASI_OFF_ERRQ, 32'h0);
    check(q, {16'h0000, MASI_NO_ERROR}, "drained");
    check(led_errors, 1'b0, "errors lamp dark");
    $display("test error queue done");
    ext_over_level <= 1'b1;
    repeat (3) @(posedge clk);
    check({led_overload, out_connect}, 2'b10, "overload");
    ext_over_level <= 1'b0;
    repeat (3) @(posedge clk);
    check({led_overload, out_connect}, 2'b01, "overload gone");
    $display("test overload done");
    rw(1'b0, 8'h1C, 32'h0);
    check(e, 1'b1, "unmapped error");
    check(q, 32'h0000_0000, "unmapped data");
    check(led_access, 1'b1, "access lit");
    repeat (MASI_ACCESS_CYC + 4) @(posedge clk);
    check(led_access, 1'b0, "access dark");
    $display("test access done");
    end_sim();
  end
endmodule : tb
